// ### pkg/pmg_consts.vh
// register indices, field layout and reset values of the multicast routing block
`ifndef PMG_CONSTS_VH
`define PMG_CONSTS_VH

// register indices; byte address is four times the index
`define PMG_IDX_CAP 10'h334
`define PMG_IDX_CTL 10'h336
`define PMG_IDX_BASE_LO 10'h338
`define PMG_IDX_BASE_HI 10'h33C
`define PMG_IDX_RCV_LO 10'h340
`define PMG_IDX_RCV_HI 10'h344
`define PMG_IDX_CFG_LOCK 10'h360

// field positions
`define PMG_FLD6_MSB 5
`define PMG_FLAG_BIT 15
`define PMG_BASE_LSB 12
`define PMG_GRP_BITS 6
`define PMG_GRP_SPAN 7'h06
`define PMG_WORD_MSB 31

// reset values
`define PMG_RST_MAXGRP 6'h1F
`define PMG_RST_ECRC 1'h1
`define PMG_RST_WORD 32'h0000_0000
`define PMG_RST_FLD6 6'h00
`define PMG_RST_BASE_LO 20'h0_0000

// axi responses
`define PMG_RESP_OKAY 2'h0
`define PMG_RESP_SLVERR 2'h2

`endif

// ### logic/pmg_multicast_router.v
// multicast group configuration registers and egress decision for one switch port
//
// Contract
// RL1 - supported groups reported as max-group field plus one, default 0x1F
// RL2 - at most 64 groups, six-bit group number
// RL3 - max-group write-locked; writable until configuration lock, e.g. to 0x3F
// RL4 - ecrc regeneration bit 15 resets to one, write-locked
// RL5 - enabled groups equal enabled-group-count plus one; bits 5:0, reset zero
// RL6 - software keeps enabled-group-count not above max-group
// RL7 - control bit 15 enables multicast; resets to zero
// RL8 - index position bits 5:0 give group number lsb in tlp address
// RL9 - software keeps index position at least 12 while enabled
// RL10 - base low holds address bits 31:12; bits 11:6 read zero
// RL11 - base high holds address bits 63:32, reset zero
// RL12 - software keeps base bits zero over group bits and below index
// RL13 - low receive mask bit n selects group n, groups 0 to 31
// RL14 - set mask bit of enabled group forwards tlp unless received here
// RL15 - mask bits above enabled-group-count are ignored
// RL16 - high receive mask covers groups 32 to 63, same forwarding
// RL17 - memory tlp in base window is multicast; group from six bits at index
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pmg_consts.vh"

module pmg_multicast_router (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // tlp offered on the partition virtual bus
    input wire tlpValid,
    input wire [63:0] tlpAddr,
    input wire tlpIsMem,
    input wire tlpFromThisPort,
    // egress decision, one cycle later
    output reg fwdValid,
    output reg fwdMulticast,
    output reg fwdForward,
    output reg [5:0] fwdGroup
);

// ------------------------------------------------------------
// reset release
// ------------------------------------------------------------
reg rstSync1;
reg rstSync2;
wire rstnInt;

// async assert, release after two edges
// every flop below sees a release aligned to sys_clk, never mid-cycle
always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        rstSync1 <= 1'b0;
        rstSync2 <= 1'b0;
    end else begin
        rstSync1 <= 1'b1;
        rstSync2 <= rstSync1;
    end
end
assign rstnInt = rstSync2;

// ------------------------------------------------------------
// configuration state
// ------------------------------------------------------------
reg [5:0] max_group_field;
reg ecrc_regen_capable;
reg [5:0] enabled_group_count;
reg multicast_global_enable;
reg [5:0] group_index_position;
reg [`PMG_WORD_MSB:`PMG_BASE_LSB] mc_base_low;
reg [31:0] mc_base_high;
// receive masks in two words; group bit 5 picks the word
reg [31:0] rcvLow;
reg [31:0] rcvHigh;
// lock stands for the end of initial configuration; only reset reopens it
reg cfgLocked;

// write channel holding state
// address and data may arrive in either order; each waits here for the other
reg awHeld;
reg wHeld;
reg [9:0] wrIdx;
reg [31:0] wrData;
reg [3:0] wrStrb;

// byte-lane merge of a write into an old word
// lanes with a low strobe keep their old bytes
function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
        laneMerge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                laneMerge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    end
endfunction

// ------------------------------------------------------------
// register read view
// ------------------------------------------------------------
reg [31:0] rdWord;
reg rdHit;

// reserved bits and unused upper halves read zero
// unmapped reads answer zero with an error response
always @* begin
    rdWord = `PMG_RST_WORD;
    rdHit = 1'b1;
    case (s_axi_araddr[11:2])
        `PMG_IDX_CAP: begin
            rdWord[`PMG_FLD6_MSB:0] = max_group_field; // RL1
            rdWord[`PMG_FLAG_BIT] = ecrc_regen_capable; // RL4
        end
        `PMG_IDX_CTL: begin
            rdWord[`PMG_FLD6_MSB:0] = enabled_group_count; // RL5
            rdWord[`PMG_FLAG_BIT] = multicast_global_enable; // RL7
        end
        `PMG_IDX_BASE_LO: begin
            rdWord[`PMG_FLD6_MSB:0] = group_index_position; // RL8
            rdWord[`PMG_WORD_MSB:`PMG_BASE_LSB] = mc_base_low; // RL10
        end
        `PMG_IDX_BASE_HI: rdWord = mc_base_high; // RL11
        `PMG_IDX_RCV_LO: rdWord = rcvLow; // RL13
        `PMG_IDX_RCV_HI: rdWord = rcvHigh; // RL16
        `PMG_IDX_CFG_LOCK: rdWord[0] = cfgLocked;
        default: rdHit = 1'b0;
    endcase
end

// ------------------------------------------------------------
// register images
// ------------------------------------------------------------
reg [31:0] capImage;
reg [31:0] ctlImage;
reg [31:0] baseLoImage;

// full-word images of the packed registers feed the lane merge; unused bits stay zero
always @* begin
    capImage = `PMG_RST_WORD;
    capImage[`PMG_FLD6_MSB:0] = max_group_field;
    capImage[`PMG_FLAG_BIT] = ecrc_regen_capable;
    ctlImage = `PMG_RST_WORD;
    ctlImage[`PMG_FLD6_MSB:0] = enabled_group_count;
    ctlImage[`PMG_FLAG_BIT] = multicast_global_enable;
    baseLoImage = `PMG_RST_WORD;
    baseLoImage[`PMG_FLD6_MSB:0] = group_index_position;
    baseLoImage[`PMG_WORD_MSB:`PMG_BASE_LSB] = mc_base_low;
end

// ------------------------------------------------------------
// axi4-lite write path
// ------------------------------------------------------------
wire wrGo;
reg [31:0] wrMerged;
reg wrHit;

// a waiting response holds off the next write, so responses stay in order
assign wrGo = awHeld && wHeld && !s_axi_bvalid;

// merged word per target, so partial strobes keep untouched lanes
always @* begin
    wrHit = 1'b1;
    case (wrIdx)
        `PMG_IDX_CAP: wrMerged = laneMerge(capImage, wrData, wrStrb);
        `PMG_IDX_CTL: wrMerged = laneMerge(ctlImage, wrData, wrStrb);
        `PMG_IDX_BASE_LO: wrMerged = laneMerge(baseLoImage, wrData, wrStrb);
        `PMG_IDX_BASE_HI: wrMerged = laneMerge(mc_base_high, wrData, wrStrb);
        `PMG_IDX_RCV_LO: wrMerged = laneMerge(rcvLow, wrData, wrStrb);
        `PMG_IDX_RCV_HI: wrMerged = laneMerge(rcvHigh, wrData, wrStrb);
        `PMG_IDX_CFG_LOCK: wrMerged = laneMerge(`PMG_RST_WORD, wrData, wrStrb);
        default: begin
            wrMerged = `PMG_RST_WORD;
            wrHit = 1'b0;
        end
    endcase
end

// address and data are taken in either order, one write at a time
always @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PMG_RESP_OKAY;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        wrIdx <= 10'h000;
        wrData <= `PMG_RST_WORD;
        wrStrb <= 4'h0;
        max_group_field <= `PMG_RST_MAXGRP; // RL1
        ecrc_regen_capable <= `PMG_RST_ECRC; // RL4
        enabled_group_count <= `PMG_RST_FLD6; // RL5
        multicast_global_enable <= 1'b0; // RL7
        group_index_position <= `PMG_RST_FLD6;
        mc_base_low <= `PMG_RST_BASE_LO;
        mc_base_high <= `PMG_RST_WORD; // RL11
        rcvLow <= `PMG_RST_WORD;
        rcvHigh <= `PMG_RST_WORD;
        cfgLocked <= 1'b0;
    end else begin
        // ready only while the slot is free and no response waits
        s_axi_awready <= !awHeld && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
        s_axi_wready <= !wHeld && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            wrIdx <= s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
        end
        if (wrGo) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `PMG_RESP_OKAY : `PMG_RESP_SLVERR;
            case (wrIdx)
                `PMG_IDX_CAP: begin
                    // locked fields only move during initial configuration
                    if (!cfgLocked) begin
                        max_group_field <= wrMerged[`PMG_FLD6_MSB:0]; // RL3
                        ecrc_regen_capable <= wrMerged[`PMG_FLAG_BIT]; // RL4
                    end
                end
                `PMG_IDX_CTL: begin
                    enabled_group_count <= wrMerged[`PMG_FLD6_MSB:0]; // RL5
                    multicast_global_enable <= wrMerged[`PMG_FLAG_BIT]; // RL7
                end
                `PMG_IDX_BASE_LO: begin
                    group_index_position <= wrMerged[`PMG_FLD6_MSB:0]; // RL8
                    mc_base_low <= wrMerged[`PMG_WORD_MSB:`PMG_BASE_LSB]; // RL10
                end
                `PMG_IDX_BASE_HI: mc_base_high <= wrMerged; // RL11
                `PMG_IDX_RCV_LO: rcvLow <= wrMerged; // RL13
                `PMG_IDX_RCV_HI: rcvHigh <= wrMerged; // RL16
                // set-only: once closed, only reset reopens it
                `PMG_IDX_CFG_LOCK: cfgLocked <= cfgLocked | wrMerged[0]; // RL3
                default: cfgLocked <= cfgLocked;
            endcase
        end
        // response leaves on the edge that sees bready
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// axi4-lite read path
// ------------------------------------------------------------
// answer one cycle after the address is taken
// rdata is captured at the handshake, so araddr may change right after
// arready stays low while an answer waits: one read at a time
always @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `PMG_RST_WORD;
        s_axi_rresp <= `PMG_RESP_OKAY;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdHit ? `PMG_RESP_OKAY : `PMG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
end

// ------------------------------------------------------------
// egress decision
// ------------------------------------------------------------
wire [6:0] topBit;
wire [63:0] winMask;
wire [63:0] baseAddr;
wire [63:0] addrShift;
wire inWindow;
wire [5:0] grp;
wire groupOn;
wire maskBit;
wire fwdNow;

// window spans the group field and everything below it; wide shifts leave an empty mask
// limitation: an index above 57 puts the top of the group field at bit 63 or beyond; the mask
// then empties and every memory address counts as inside the window
// topBit is seven bits so index plus group width never wraps
assign topBit = {1'b0, group_index_position} + `PMG_GRP_SPAN; // RL17
assign winMask = ~((64'h0000_0000_0000_0001 << topBit) - 64'h0000_0000_0000_0001);
assign baseAddr = {mc_base_high, mc_base_low, 12'h000};
assign inWindow = tlpIsMem && ((tlpAddr & winMask) == (baseAddr & winMask)); // RL17
assign addrShift = tlpAddr >> group_index_position; // RL8
assign grp = addrShift[`PMG_GRP_BITS-1:0]; // RL2
assign groupOn = (grp <= enabled_group_count); // RL15
assign maskBit = grp[5] ? rcvHigh[grp[4:0]] : rcvLow[grp[4:0]]; // RL13 RL16
// own-port test sits only here, so fwdMulticast still reports window hits
assign fwdNow = multicast_global_enable && inWindow && groupOn && maskBit &&
    !tlpFromThisPort; // RL14

// registered so every output leaves a flip-flop
// fwdGroup loads every cycle and only means something beside fwdValid
always @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
        fwdValid <= 1'b0;
        fwdMulticast <= 1'b0;
        fwdForward <= 1'b0;
        fwdGroup <= 6'h00;
    end else begin
        fwdValid <= tlpValid;
        fwdMulticast <= tlpValid && multicast_global_enable && inWindow; // RL7
        fwdForward <= tlpValid && fwdNow; // RL14
        fwdGroup <= grp;
    end
end

endmodule

// ### dv/pmg_router_assertions.sv
// concurrent checks on the ports of the multicast router
`timescale 1ns/1ps
module pmg_router_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // tlp in, decision out
    input wire logic tlpValid,
    input wire logic tlpIsMem,
    input wire logic tlpFromThisPort,
    input wire logic fwdValid,
    input wire logic fwdMulticast,
    input wire logic fwdForward
);
    // one clock domain, quiet while reset is low
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // decision pipeline
    fwd_pulse_a: assert property (tlpValid |=> fwdValid)
        else $error("decision pulse missing");
    fwd_idle_a: assert property (!tlpValid |=> !fwdValid && !fwdForward)
        else $error("decision without tlp");
    own_port_a: assert property (tlpValid && tlpFromThisPort |=> !fwdForward)
        else $error("own tlp forwarded");
    non_mem_a: assert property (tlpValid && !tlpIsMem |=> !fwdMulticast)
        else $error("non memory tlp taken as multicast");
    fwd_needs_mc_a: assert property (fwdForward |-> fwdMulticast && fwdValid)
        else $error("forward without multicast");
    // register bus timing
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address ready too early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule

// ### dv/pmg_switch_peer.sv
// model of the other switch ports offering tlps on the virtual bus
`timescale 1ns/1ps
module pmg_switch_peer (
    // clock and offer from the bench
    input wire logic sys_clk,
    input wire logic offer,
    input wire logic [63:0] offerAddr,
    input wire logic offerMem,
    input wire logic offerFrom,
    // tlp towards the router
    output logic tlpValid = 1'b0,
    output logic [63:0] tlpAddr = 64'h0,
    output logic tlpIsMem = 1'b0,
    output logic tlpFromThisPort = 1'b0
);
    // idle fields toggle so a stale tlp never looks valid
    always @(posedge sys_clk) begin
        tlpValid <= offer;
        tlpAddr <= offer ? offerAddr : ~tlpAddr;
        tlpIsMem <= offer ? offerMem : ~tlpIsMem;
        tlpFromThisPort <= offer ? offerFrom : ~tlpFromThisPort;
    end
endmodule

// ### dv/tb.sv
// self-checking bench for the multicast router
`timescale 1ns/1ps
`include "pmg_consts.vh"
module tb;
    // ------------------------------------------------------------
    // signals, shadow state and tables
    // ------------------------------------------------------------
    logic sys_clk = 1'b0, rstn = 1'b0, offer = 1'b0, offerMem = 1'b0, offerFrom = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'hbe6e;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, en = 1'b0, pend = 1'b0, live = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tlpValid, tlpIsMem, tlpFromThisPort, fwdValid, fwdMulticast, fwdForward;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [5:0] fwdGroup, ng = 6'h00, ip = 6'h00;
    logic [63:0] tlpAddr, offerAddr = 64'h0, base = 64'h0, rmask = 64'h0;
    logic [7:0] pexp;
    int bad_count = 0, comparisons = 0;
    localparam logic [11:0] RA [7] = '{12'hcd0, 12'hcd8, 12'hce0, 12'hcf0, 12'hd00,
        12'hd10, 12'hd84};
    localparam logic [31:0] WV [7] = '{32'h0000_803f, 32'h0000_803f, 32'hffff_f03f,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000};

    // free running core clock
    always #20 sys_clk = ~sys_clk;

    pmg_multicast_router pmg_multicast_router_inst (.sys_clk, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tlpValid, .tlpAddr, .tlpIsMem, .tlpFromThisPort, .fwdValid,
        .fwdMulticast, .fwdForward, .fwdGroup);
    pmg_switch_peer pmg_switch_peer_inst (.sys_clk, .offer, .offerAddr, .offerMem,
        .offerFrom, .tlpValid, .tlpAddr, .tlpIsMem, .tlpFromThisPort);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // predicted {multicast, forward, group}; base bits below the group are masked
    function automatic logic [7:0] expect_fwd(input logic [63:0] a, input logic m, f);
        logic [63:0] msk;
        logic [5:0] g;
        logic mc;
        msk = ~((64'h1 << (ip + 6)) - 64'h1);
        g = 6'(a >> ip);
        mc = en & m & ((a & msk) == (base & msk));
        return {mc, mc & (g <= ng) & rmask[g] & !f, g};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed, "rdata");
        chk(s_axi_rresp, er, "rresp");
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // each decision against the prediction made when its tlp was seen
    always @(posedge sys_clk) begin
        if (live) begin
            chk(fwdValid, pend, "fwdValid");
            if (pend) begin
                chk(fwdMulticast, pexp[7], "fwdMulticast");
                chk(fwdForward, pexp[6], "fwdForward");
                chk(fwdGroup, pexp[5:0], "fwdGroup");
            end
        end
        pend <= tlpValid;
        pexp <= expect_fwd(tlpAddr, tlpIsMem, tlpFromThisPort);
    end

    // main sequence: reset values, writable bits, lock, then random traffic
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        live <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rsp = (i == 6) ? `PMG_RESP_SLVERR : `PMG_RESP_OKAY;
            rd(RA[i], (i == 0) ? 32'h0000_801f : 32'h0000_0000, rsp);
            wr(RA[i], 32'hffff_ffff, rsp);
            rd(RA[i], WV[i], rsp);
        end
        wr(12'hd80, 32'h0000_0001, `PMG_RESP_OKAY);
        wr(12'hcd0, 32'h0000_0000, `PMG_RESP_OKAY);
        rd(12'hcd0, 32'h0000_803f, `PMG_RESP_OKAY);
        // byte lane write: only lane 1 of the high base word may change
        s_axi_wstrb <= 4'h2;
        wr(12'hcf0, 32'h0000_0000, `PMG_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(12'hcf0, 32'hffff_00ff, `PMG_RESP_OKAY);
        for (int r = 0; r < 24; r++) begin
            en = (r % 4 != 3);
            ip = 6'd12 + 6'(rnd() % 29);
            ng = (r % 3 == 0) ? 6'h3f : 6'(rnd());
            base = {rnd(), rnd()} & ~((64'h1 << (ip + 6)) - 64'h1);
            rmask = (r % 5 == 0) ? '1 : {rnd(), rnd()};
            wr(12'hcd8, {16'h0000, en, 9'h000, ng}, `PMG_RESP_OKAY);
            wr(12'hce0, {base[31:12], 6'h00, ip}, `PMG_RESP_OKAY);
            wr(12'hcf0, base[63:32], `PMG_RESP_OKAY);
            wr(12'hd00, rmask[31:0], `PMG_RESP_OKAY);
            wr(12'hd10, rmask[63:32], `PMG_RESP_OKAY);
            // mostly back to back tlps, half aimed into the window
            for (int k = 0; k < 64; k++) begin
                @(posedge sys_clk);
                offer <= (k % 8 != 7);
                offerMem <= (rnd() % 4 != 0);
                offerFrom <= (rnd() % 6 == 0);
                offerAddr <= k[0] ? {rnd(), rnd()} : base | ({58'h0, 6'(rnd())} << ip)
                    | (64'(rnd()) & ((64'h1 << ip) - 64'h1));
            end
            @(posedge sys_clk);
            offer <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        // second reset in mid-run: defaults return and the lock opens again
        rstn <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(12'hcd0, 32'h0000_801f, `PMG_RESP_OKAY);
        rd(12'hcd8, 32'h0000_0000, `PMG_RESP_OKAY);
        wr(12'hcd0, 32'h0000_0000, `PMG_RESP_OKAY);
        rd(12'hcd0, 32'h0000_0000, `PMG_RESP_OKAY);
        report_and_stop();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
endmodule

bind pmg_multicast_router pmg_router_checker pmg_router_checker_inst (.sys_clk, .rstn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tlpValid, .tlpIsMem,
    .tlpFromThisPort, .fwdValid, .fwdMulticast, .fwdForward);
